// ==== shared/ptdd_pkg.sv ====
// constants and register map of the phy test, diagnostics and downshift block
// How it works
// - reverse loopback turns line receive data around and sends it back out
// - in reverse loopback the mac transmit side is ignored entirely
// - a control bit also copies looped receive data to the mac side
// - self test transmit data comes from a 15-bit prbs generator
// - prbs data is sent as packets with gaps; generator and checker independent
// - checker compares received bytes against its own lfsr reference
// - mismatching received bytes are counted in the error byte register after the checker first locks
// - status shows checker lock, sync lost and generator busy
// - all bytes seen by the checker are counted in their own register
// - continuous bit makes full self test counters wrap to zero
// - one control bit picks 64 or 1518 byte packets
// - cable test keeps the first five reflections of a pair
// - after a cross fault: first cross location plus up to four reflections
// - auto bit starts a cable test when the link drops; results stay readable
// - energy detect compares filtered level to thresholds with hysteresis
// - energy thresholds and listening times are programmable
// - downshift to 100 after a set count of failed gigabit tries, default four
// - enhanced mode downshifts after one failure when c and d are quiet
// - failing at gigabit and at 100 falls back further to 10
// - fast link detect modes sit in the third configuration register
// - reverse loopback is selected through the self test control register
package ptdd_pkg;
    localparam logic [6:0] ADR_CFG_ONE = 7'h09;
    localparam logic [6:0] ADR_ST_CTRL = 7'h16;
    localparam logic [6:0] ADR_ST_STAT = 7'h17;
    localparam logic [6:0] ADR_FAST_LINK = 7'h1E;
    localparam logic [6:0] ADR_RX_BYTES = 7'h71;
    localparam logic [6:0] ADR_ERR_BYTES = 7'h72;
    localparam logic [6:0] ADR_ENERGY_THR = 7'h40;
    localparam logic [6:0] ADR_ENERGY_LISTEN = 7'h41;
    localparam logic [6:0] ADR_DOWNSHIFT = 7'h42;
    localparam logic [6:0] ADR_TDR_BASE = 7'h48;
    localparam logic [6:0] ADR_TDR_STAT = 7'h4D;

    localparam int CFG_AUTO_TDR_BIT = 7;
    localparam int CTRL_START_BIT = 15;
    localparam int CTRL_CONT_BIT = 14;
    localparam int CTRL_LONG_BIT = 13;
    localparam int CTRL_MAC_FWD_BIT = 5;
    localparam int CTRL_LOOP_LSB = 0;
    localparam int LOOP_W = 5;
    localparam logic [4:0] LOOP_REVERSE = 5'h10;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SYNC_LOST_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int TDR_CROSS_BIT = 3;
    localparam int THR_ON_LSB = 8;
    localparam int THR_OFF_LSB = 0;
    localparam int DS_EN_BIT = 0;
    localparam int DS_ENH_BIT = 1;
    localparam int DS_CNT_LSB = 2;

    localparam logic [15:0] RST_CFG_ONE = 16'h0000;
    localparam logic [15:0] RST_ST_CTRL = 16'h0000;
    localparam logic [15:0] RST_FAST_LINK = 16'h0000;
    localparam logic [15:0] RST_ENERGY_THR = 16'h2010;
    localparam logic [15:0] RST_ENERGY_LISTEN = 16'h0020;
    localparam logic [15:0] RST_DOWNSHIFT = 16'h0010;
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;

    localparam logic [10:0] PKT_SHORT = 11'h040;
    localparam logic [10:0] PKT_LONG = 11'h5EE;
    localparam logic [3:0] IPG_BYTES = 4'hC;
    localparam logic [3:0] LOCK_BYTES = 4'h8;
    localparam logic [2:0] TDR_SLOTS = 3'h5;
    localparam logic [2:0] TDR_SLOTS_CROSS = 3'h4;
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 16;

    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
endpackage

// ==== hdl/ptdd_fifo.sv ====
// byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module ptdd_fifo #(
    parameter int WIDTH = ptdd_pkg::FIFO_W, // word width
    parameter int DEPTH = ptdd_pkg::FIFO_DEPTH // entries, power of two
) (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, low
    input wire logic clr, // flush all entries
    input wire logic in_valid, // write request
    output logic in_ready, // room left
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // reader takes word
    output logic [WIDTH-1:0] out_data // head word
);
    import ptdd_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic room;
    } ptdd_fifo_st_t;
    ptdd_fifo_st_t st_reg, st_next;
    logic push, pop;

    assign in_ready = st_reg.room;
    assign out_valid = (st_reg.cnt != '0);
    assign out_data = st_reg.mem[st_reg.rp];
    assign push = in_valid & st_reg.room;
    assign pop = out_valid & out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (clr) begin
            st_next.wp = '0;
            st_next.rp = '0;
            st_next.cnt = '0;
        end
        // ready kept as a flop so the source sees no combinational path
        st_next.room = (st_next.cnt != DEPTH[AW:0]);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.room <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// ==== hdl/ptdd_top.sv ====
// loopback, prbs self test, cable test capture, energy detect and downshift
`timescale 1ns/1ps
module ptdd_top (
    input wire logic clk, // core clock, 50 MHz
    input wire logic rst_b, // async reset, low
    input wire logic [6:0] reg_addr, // management register address
    input wire logic reg_wr, // write strobe
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata, // read data, one cycle after address
    input wire logic [7:0] mac_tx_data, // mac transmit byte
    input wire logic mac_tx_en, // mac transmit valid
    output logic [7:0] mac_rx_data, // byte toward mac
    output logic mac_rx_valid, // byte toward mac valid
    input wire logic [7:0] line_rx_data, // byte from receiver
    input wire logic line_rx_valid, // receiver byte valid
    output logic line_rx_ready, // receive path can take a byte
    output logic [7:0] line_tx_data, // byte to transmitter
    output logic line_tx_en, // transmit byte valid
    input wire logic line_tx_ready, // transmitter takes byte
    input wire logic link_up, // link status
    input wire logic gig_fail, // failed gigabit attempt, pulse
    input wire logic fe_fail, // failed 100 attempt, pulse
    input wire logic energy_cd, // energy seen on pairs c and d
    input wire logic [7:0] sig_level, // iir filtered signal level
    output logic energy_det, // signal present
    output logic [1:0] speed_sel, // allowed top speed
    output logic [15:0] fast_link_mode, // fast link detect setup
    output logic tdr_start, // start cable test, pulse
    input wire logic tdr_refl_valid, // reflection result strobe
    input wire logic tdr_refl_cross, // result is a cross fault
    input wire logic [15:0] tdr_refl_data // result location and size
);
    import ptdd_pkg::*;

    typedef struct packed {
        logic [15:0] config_one_auto_cable_test;
        logic [15:0] self_test_control;
        logic [15:0] fast_link_config;
        logic [15:0] energy_thr;
        logic [15:0] energy_listen;
        logic [15:0] downshift_cfg;
        logic [15:0] rdata;
        logic start_q;
        logic [14:0] gen_lfsr;
        logic [10:0] gen_cnt;
        logic [3:0] gen_gap;
        logic gen_busy;
        logic [14:0] chk_lfsr;
        logic [3:0] chk_run;
        logic locked;
        logic sync_lost;
        logic [15:0] rx_bytes;
        logic [15:0] err_bytes;
        logic [7:0] tx_data;
        logic tx_en;
        logic [7:0] mrx_data;
        logic mrx_valid;
        logic [4:0][15:0] tdr_slot;
        logic [2:0] tdr_refl;
        logic tdr_cross;
        logic tdr_start;
        logic link_q;
        logic e_det;
        logic [15:0] e_cnt;
        logic [1:0] speed;
        logic [2:0] ds_fails;
    } ptdd_st_t;

    ptdd_st_t st_reg, st_next;
    logic rev, test_on, start_rise, cont, gen_go, chk_act, fifo_valid, fifo_pop;
    logic [7:0] fifo_data, chk_ref;
    logic [14:0] gen_nx, chk_nx;
    logic [10:0] pkt_len;

    function automatic logic [14:0] prbs_step8(input logic [14:0] s);
        logic [14:0] v;
        v = s;
        for (int i = 0; i < 8; i++) begin
            v = {v[13:0], v[14] ^ v[13]};
        end
        return v;
    endfunction

    function automatic logic [15:0] bump(input logic [15:0] v, input logic wrap);
        logic [15:0] r;
        r = v + 16'h0001;
        // saturating hold keeps the worst case visible to slow pollers
        if (v == 16'hFFFF && !wrap) begin
            r = v;
        end
        return r;
    endfunction

    assign rev = (st_reg.self_test_control[CTRL_LOOP_LSB +: LOOP_W] == LOOP_REVERSE);
    assign test_on = st_reg.self_test_control[CTRL_START_BIT];
    assign start_rise = test_on & ~st_reg.start_q;
    assign cont = st_reg.self_test_control[CTRL_CONT_BIT];
    assign pkt_len = st_reg.self_test_control[CTRL_LONG_BIT] ? PKT_LONG : PKT_SHORT;
    assign gen_go = test_on & ~rev & (line_tx_ready | ~st_reg.tx_en);
    assign chk_act = test_on & ~rev & line_rx_valid;
    assign fifo_pop = rev & (line_tx_ready | ~st_reg.tx_en);
    assign gen_nx = prbs_step8(st_reg.gen_lfsr);
    assign chk_nx = prbs_step8(st_reg.chk_lfsr);
    assign chk_ref = chk_nx[7:0];

    // the loop buffer is flushed whenever reverse loopback is off
    ptdd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_loop_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .clr(~rev),
        .in_valid(line_rx_valid & rev),
        .in_ready(line_rx_ready),
        .in_data(line_rx_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    always_comb begin
        logic [15:0] rd;
        logic [15:0] lvl;
        rd = '0;
        lvl = {8'h00, sig_level};
        st_next = st_reg;
        st_next.start_q = test_on;
        st_next.tdr_start = 1'b0;

        if (reg_wr) begin
            case (reg_addr)
                ADR_CFG_ONE: st_next.config_one_auto_cable_test = reg_wdata;
                ADR_ST_CTRL: st_next.self_test_control = reg_wdata;
                ADR_FAST_LINK: st_next.fast_link_config = reg_wdata;
                ADR_ENERGY_THR: st_next.energy_thr = reg_wdata;
                ADR_ENERGY_LISTEN: st_next.energy_listen = reg_wdata;
                ADR_DOWNSHIFT: st_next.downshift_cfg = reg_wdata;
                default: ;
            endcase
        end

        // transmit side: loop buffer, generator or mac
        if (rev) begin
            if (fifo_pop) begin
                st_next.tx_en = fifo_valid;
                st_next.tx_data = fifo_data;
            end
        end else if (test_on) begin
            if (gen_go) begin
                if (st_reg.gen_gap != 4'h0) begin
                    st_next.tx_en = 1'b0;
                    st_next.gen_gap = st_reg.gen_gap - 4'h1;
                end else begin
                    st_next.tx_en = 1'b1;
                    st_next.tx_data = gen_nx[7:0];
                    st_next.gen_lfsr = gen_nx;
                    if (st_reg.gen_cnt == pkt_len - 11'h001) begin
                        st_next.gen_cnt = '0;
                        st_next.gen_gap = IPG_BYTES;
                    end else begin
                        st_next.gen_cnt = st_reg.gen_cnt + 11'h001;
                    end
                end
            end
        end else begin
            st_next.tx_en = mac_tx_en;
            st_next.tx_data = mac_tx_data;
        end
        st_next.gen_busy = test_on & ~rev;

        // mac receive side
        st_next.mrx_valid = line_rx_valid & (~rev | st_reg.self_test_control[CTRL_MAC_FWD_BIT]);
        st_next.mrx_data = line_rx_data;

        // checker resyncs itself from the received bytes
        if (chk_act) begin
            st_next.chk_lfsr = {st_reg.chk_lfsr[6:0], line_rx_data};
            st_next.rx_bytes = bump(st_reg.rx_bytes, cont);
            if (line_rx_data == chk_ref) begin
                if (st_reg.chk_run == LOCK_BYTES - 4'h1) begin
                    st_next.locked = 1'b1;
                    st_next.sync_lost = 1'b0;
                end else begin
                    st_next.chk_run = st_reg.chk_run + 4'h1;
                end
            end else begin
                st_next.chk_run = '0;
                if (st_reg.locked || st_reg.sync_lost) begin
                    st_next.err_bytes = bump(st_reg.err_bytes, cont);
                end
                if (st_reg.locked) begin
                    st_next.locked = 1'b0;
                    st_next.sync_lost = 1'b1;
                end
            end
        end
        if (start_rise) begin
            st_next.gen_lfsr = PRBS_SEED;
            st_next.gen_cnt = '0;
            st_next.gen_gap = '0;
            st_next.chk_run = '0;
            st_next.locked = 1'b0;
            st_next.sync_lost = 1'b0;
            st_next.rx_bytes = '0;
            st_next.err_bytes = '0;
        end

        // cable test trigger and capture
        st_next.link_q = link_up;
        if (st_reg.config_one_auto_cable_test[CFG_AUTO_TDR_BIT] && st_reg.link_q && !link_up) begin
            st_next.tdr_start = 1'b1;
            st_next.tdr_slot = '0;
            st_next.tdr_refl = '0;
            st_next.tdr_cross = 1'b0;
        end else if (tdr_refl_valid) begin
            if (tdr_refl_cross) begin
                if (!st_reg.tdr_cross) begin
                    st_next.tdr_cross = 1'b1;
                    st_next.tdr_slot[4] = tdr_refl_data;
                    if (st_reg.tdr_refl > TDR_SLOTS_CROSS) begin
                        st_next.tdr_refl = TDR_SLOTS_CROSS;
                    end
                end
            end else if (st_reg.tdr_refl < (st_reg.tdr_cross ? TDR_SLOTS_CROSS : TDR_SLOTS)) begin
                st_next.tdr_slot[st_reg.tdr_refl] = tdr_refl_data;
                st_next.tdr_refl = st_reg.tdr_refl + 3'h1;
            end
        end

        // energy detect: level must hold past a threshold for the listen time
        if (st_reg.e_det ? (lvl < {8'h00, st_reg.energy_thr[THR_OFF_LSB +: 8]})
                         : (lvl >= {8'h00, st_reg.energy_thr[THR_ON_LSB +: 8]})) begin
            if (st_reg.e_cnt >= st_reg.energy_listen) begin
                st_next.e_det = ~st_reg.e_det;
                st_next.e_cnt = '0;
            end else begin
                st_next.e_cnt = st_reg.e_cnt + 16'h0001;
            end
        end else begin
            st_next.e_cnt = '0;
        end

        // downshift
        if (!st_reg.downshift_cfg[DS_EN_BIT]) begin
            st_next.speed = SPD_1000;
            st_next.ds_fails = '0;
        end else if (link_up) begin
            st_next.ds_fails = '0;
        end else if (gig_fail && st_reg.speed == SPD_1000) begin
            if ((st_reg.downshift_cfg[DS_ENH_BIT] && !energy_cd)
                || (st_reg.ds_fails + 3'h1 >= st_reg.downshift_cfg[DS_CNT_LSB +: 3])) begin
                st_next.speed = SPD_100;
                st_next.ds_fails = '0;
            end else begin
                st_next.ds_fails = st_reg.ds_fails + 3'h1;
            end
        end else if (fe_fail && st_reg.speed == SPD_100) begin
            st_next.speed = SPD_10;
        end

        case (reg_addr)
            ADR_CFG_ONE: rd = st_reg.config_one_auto_cable_test;
            ADR_ST_CTRL: rd = st_reg.self_test_control;
            ADR_ST_STAT: begin
                rd[STAT_LOCK_BIT] = st_reg.locked;
                rd[STAT_SYNC_LOST_BIT] = st_reg.sync_lost;
                rd[STAT_BUSY_BIT] = st_reg.gen_busy;
            end
            ADR_FAST_LINK: rd = st_reg.fast_link_config;
            ADR_RX_BYTES: rd = st_reg.rx_bytes;
            ADR_ERR_BYTES: rd = st_reg.err_bytes;
            ADR_ENERGY_THR: rd = st_reg.energy_thr;
            ADR_ENERGY_LISTEN: rd = st_reg.energy_listen;
            ADR_DOWNSHIFT: rd = st_reg.downshift_cfg;
            ADR_TDR_STAT: rd = {12'h000, st_reg.tdr_cross, st_reg.tdr_refl};
            default: begin
                if (reg_addr >= ADR_TDR_BASE && reg_addr < ADR_TDR_BASE + 7'h05) begin
                    rd = st_reg.tdr_slot[3'(reg_addr - ADR_TDR_BASE)];
                end
            end
        endcase
        st_next.rdata = rd;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.config_one_auto_cable_test <= RST_CFG_ONE;
            st_reg.self_test_control <= RST_ST_CTRL;
            st_reg.fast_link_config <= RST_FAST_LINK;
            st_reg.energy_thr <= RST_ENERGY_THR;
            st_reg.energy_listen <= RST_ENERGY_LISTEN;
            st_reg.downshift_cfg <= RST_DOWNSHIFT;
            st_reg.gen_lfsr <= PRBS_SEED;
            st_reg.speed <= SPD_1000;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign mac_rx_data = st_reg.mrx_data;
    assign mac_rx_valid = st_reg.mrx_valid;
    assign line_tx_data = st_reg.tx_data;
    assign line_tx_en = st_reg.tx_en;
    assign energy_det = st_reg.e_det;
    assign speed_sel = st_reg.speed;
    assign fast_link_mode = st_reg.fast_link_config;
    assign tdr_start = st_reg.tdr_start;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_rev_mac_ignored: assert property (
        rev && !fifo_valid && fifo_pop |=> !line_tx_en)
        else $error("mac data leaked in reverse loopback");
    a_rev_loop_tx: assert property (
        rev && fifo_valid && fifo_pop |=> line_tx_en && line_tx_data == $past(fifo_data))
        else $error("looped byte not retransmitted");
    a_rev_fwd_off: assert property (
        rev && !st_reg.self_test_control[CTRL_MAC_FWD_BIT] |=> !mac_rx_valid)
        else $error("mac forward active while disabled");
    a_rev_fwd_copy: assert property (
        rev && st_reg.self_test_control[CTRL_MAC_FWD_BIT] && line_rx_valid
        |=> mac_rx_valid && mac_rx_data == $past(line_rx_data))
        else $error("mac forward copy wrong");
    a_chk_match: assert property (
        chk_act && !start_rise && line_rx_data == chk_ref |=> $stable(st_reg.err_bytes))
        else $error("error counted on matching byte");
    a_err_count: assert property (
        chk_act && !start_rise && st_reg.locked && line_rx_data != chk_ref
        && st_reg.err_bytes != 16'hFFFF |=> st_reg.err_bytes == $past(st_reg.err_bytes) + 16'h1)
        else $error("error byte not counted");
    a_rx_count: assert property (
        chk_act && !start_rise && st_reg.rx_bytes != 16'hFFFF
        |=> st_reg.rx_bytes == $past(st_reg.rx_bytes) + 16'h1)
        else $error("received byte not counted");
    a_cnt_wrap: assert property (
        chk_act && !start_rise && cont && st_reg.rx_bytes == 16'hFFFF |=> st_reg.rx_bytes == '0)
        else $error("counter did not wrap");
    a_cnt_saturate: assert property (
        chk_act && !start_rise && !cont && st_reg.rx_bytes == 16'hFFFF
        |=> st_reg.rx_bytes == 16'hFFFF)
        else $error("counter did not saturate");
    // the first gap slot only opens once the transmitter has taken the last byte
    a_pkt_gap: assert property (
        gen_go && !rev && st_reg.gen_gap == 4'h0 && st_reg.gen_cnt == pkt_len - 11'h001
        ##1 gen_go |=> st_reg.gen_gap == IPG_BYTES - 4'h1 && !line_tx_en)
        else $error("no gap after packet");
    a_tdr_five: assert property (st_reg.tdr_refl <= TDR_SLOTS)
        else $error("too many reflections kept");
    a_tdr_cross: assert property (st_reg.tdr_cross |-> st_reg.tdr_refl <= TDR_SLOTS_CROSS)
        else $error("cross fault kept too many reflections");
    a_tdr_auto: assert property (
        st_reg.config_one_auto_cable_test[CFG_AUTO_TDR_BIT] && $fell(link_up)
        |=> tdr_start ##1 !tdr_start)
        else $error("cable test not started on link drop");
    a_energy_hold: assert property (
        !energy_det && sig_level < st_reg.energy_thr[THR_ON_LSB +: 8] |=> !energy_det)
        else $error("energy detect rose below threshold");
    a_ds_enhanced: assert property (
        st_reg.downshift_cfg[DS_EN_BIT] && st_reg.downshift_cfg[DS_ENH_BIT] && !link_up
        && !energy_cd && gig_fail && speed_sel == SPD_1000 |=> speed_sel == SPD_100)
        else $error("enhanced downshift missed");
    a_ds_ten: assert property (
        st_reg.downshift_cfg[DS_EN_BIT] && !link_up && !gig_fail && fe_fail
        && speed_sel == SPD_100 |=> speed_sel == SPD_10)
        else $error("no fallback to 10");

    c_lock: cover property (chk_act ##1 st_reg.locked);
    c_tdr_run: cover property (tdr_start ##[1:50] tdr_refl_valid);
    c_ten: cover property (speed_sel == SPD_100 ##[1:100] speed_sel == SPD_10);
    c_rev_tx: cover property (rev && line_tx_en && line_tx_ready);
endmodule

// ==== testbench/ptdd_partner.sv ====
// far-end link partner: sends bytes on request, takes back what the phy transmits
`timescale 1ns/1ps
module ptdd_partner (
    input wire logic clk, // core clock
    input wire logic go, // send one byte now
    input wire logic loop, // cable fixture: echo phy transmit, xor byte_in as error mask
    input wire logic [7:0] byte_in, // byte to send
    input wire logic stall, // hold off the phy transmitter
    output logic [7:0] rx_data = 8'h00, // toward phy receiver
    output logic rx_valid = 1'b0, // byte valid
    input wire logic [7:0] tx_data, // from phy transmitter
    input wire logic tx_en, // transmit byte valid
    output logic tx_ready = 1'b1, // byte accepted
    output logic [7:0] heard = 8'h00 // last byte taken
);
    // nonblocking on the rising edge: the phy sees each change one edge later, no race
    always @(posedge clk) begin
        tx_ready <= !stall;
        rx_valid <= go | (loop & tx_en & tx_ready); // silent between sends
        rx_data <= go ? byte_in : loop ? tx_data ^ byte_in : ~rx_data;
        if (tx_en && tx_ready) heard <= tx_data;
    end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the test, diagnostics and downshift block
`timescale 1ns/1ps
module testbench;
    import ptdd_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, tx_en = 0, link = 0, gf = 0, ff = 0, ecd = 0, go = 0;
    logic stall = 0, tv = 0, tc = 0, lp = 0, mv, ed, ts, tx_e, tx_r, rvl, lr;
    logic [6:0] ad = 7'h00;
    logic [7:0] mtx = 8'hA5, lvl = 8'h00, byt = 8'h00, rxd, txd, hd, md, mq;
    logic [15:0] wd = 16'h0000, td = 16'h0000, rdat, flm, f;
    logic [1:0] spd;
    logic [7:0] lv [4] = '{8'h00, 8'h18, 8'h08, 8'h18};
    logic [31:0] seed = 32'h3B70;
    int fail_count = 0, checked = 0, mcnt = 0, tcnt = 0, rcnt = 0, m0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (mv === 1'b1) begin
            mcnt++;
            mq = md;
        end
        if (rvl === 1'b1) rcnt++;
    end
    always @(posedge clk) if (ts === 1'b1) tcnt++;
    ptdd_top DUT (.clk(clk), .rst_b(rst_b), .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd),
        .reg_rdata(rdat), .mac_tx_data(mtx), .mac_tx_en(tx_en), .mac_rx_data(md),
        .mac_rx_valid(mv), .line_rx_data(rxd), .line_rx_valid(rvl), .line_rx_ready(lr),
        .line_tx_data(txd), .line_tx_en(tx_e), .line_tx_ready(tx_r), .link_up(link),
        .gig_fail(gf), .fe_fail(ff), .energy_cd(ecd), .sig_level(lvl), .energy_det(ed),
        .speed_sel(spd), .fast_link_mode(flm), .tdr_start(ts), .tdr_refl_valid(tv),
        .tdr_refl_cross(tc), .tdr_refl_data(td));
    ptdd_partner PEER (.clk(clk), .go(go), .loop(lp), .byte_in(byt), .stall(stall),
        .rx_data(rxd), .rx_valid(rvl), .tx_data(txd), .tx_en(tx_e), .tx_ready(tx_r), .heard(hd));
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(logic [6:0] a, logic [15:0] d);
        ad = a; wd = d; wr = 1;
        @(negedge clk) wr = 0;
        // idle edge so a following write never re-raises the strobe in the same step
        @(negedge clk);
    endtask
    task automatic r(logic [6:0] a, logic [15:0] e, string n);
        ad = a;
        @(negedge clk) chk(n, e, rdat);
    endtask
    // three edges: count and output both register on the pulse edge, two spare
    task automatic p(ref logic s);
        s = 1;
        @(negedge clk) s = 0;
        repeat (2) @(negedge clk);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1;
        r(ADR_ENERGY_THR, RST_ENERGY_THR, "thr");
        r(ADR_ENERGY_LISTEN, RST_ENERGY_LISTEN, "listen");
        r(7'h7F, 16'h0000, "unmapped");
        w(ADR_RX_BYTES, 16'h1234);
        r(ADR_RX_BYTES, 16'h0000, "ro count");
        seed = nx(seed);
        w(ADR_FAST_LINK, seed[15:0]);
        r(ADR_FAST_LINK, seed[15:0], "fast rd");
        chk("fast out", seed[15:0], flm);
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            lvl = (i == 0) ? {3'h1, seed[20:16]} : lv[i];
            repeat (40) @(negedge clk);
            chk("energy", {15'h0, i < 2}, {15'h0, ed});
        end
        $display("energy done");
        w(ADR_DOWNSHIFT, 16'h0011);
        for (int i = 1; i <= 4; i++) begin
            p(gf);
            chk("gig", (i < 4) ? 16'h2 : 16'h1, {14'h0, spd});
        end
        p(ff);
        chk("fe", 16'h0000, {14'h0, spd});
        w(ADR_DOWNSHIFT, 16'h0000);
        w(ADR_DOWNSHIFT, 16'h0013);
        p(gf);
        chk("enh", 16'h0001, {14'h0, spd});
        $display("downshift done");
        w(ADR_CFG_ONE, 16'h0080);
        link = 1;
        @(negedge clk) link = 0;
        repeat (3) @(negedge clk);
        chk("tdr go", 16'h0001, 16'(tcnt));
        for (int i = 0; i < 6; i++) begin
            seed = nx(seed);
            td = seed[15:0];
            if (i == 0) f = td;
            p(tv);
        end
        r(ADR_TDR_STAT, 16'h0005, "slots");
        r(ADR_TDR_BASE, f, "slot0");
        tc = 1;
        td = 16'hC0DE;
        p(tv);
        r(ADR_TDR_STAT, 16'h000C, "cross");
        r(ADR_TDR_BASE + 7'h04, 16'hC0DE, "cross at");
        $display("cable test done");
        w(ADR_ST_CTRL, 16'h0010);
        tx_en = 1;
        for (int i = 0; i < 2; i++) begin
            seed = nx(seed);
            byt = seed[7:0] ^ 8'h5A;
            m0 = mcnt;
            stall = i;
            go = 1;
            @(negedge clk) go = 0;
            repeat (4) @(negedge clk);
            stall = 0;
            repeat (3) @(negedge clk);
            chk("echo", {8'h0, byt}, {8'h0, hd});
            chk("mac copy", 16'(i), 16'(mcnt - m0));
            w(ADR_ST_CTRL, 16'h0030);
        end
        chk("mac data", {8'h0, byt}, {8'h0, mq});
        chk("rx ready", 16'h0001, {15'h0, lr});
        $display("loopback done");
        w(ADR_ST_CTRL, 16'h8000);
        repeat (3) @(negedge clk);
        r(ADR_ST_STAT, 16'h0001, "busy");
        byt = 8'h00;
        m0 = rcnt;
        lp = 1;
        repeat (150) @(negedge clk);
        lp = 0;
        repeat (3) @(negedge clk);
        r(ADR_ST_STAT, 16'h0005, "lock");
        r(ADR_RX_BYTES, 16'(rcnt - m0), "rx count");
        r(ADR_ERR_BYTES, 16'h0000, "no errors");
        // a fixed xor mask makes every echoed byte miss the reference
        byt = 8'h01;
        lp = 1;
        repeat (40) @(negedge clk);
        r(ADR_ST_STAT, 16'h0003, "sync lost");
        $display("self test done");
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
endmodule
